/* File: rtl/rlsf_flags.sv */
// Behaviour
// R1: A run of 4 zeros (E1) or 8 zeros (T1) latches the zero-run flag.
// R2: A run of 16 zeros latches the long-zero-run flag.
// R3: An HDB3 (E1) or B8ZS (T1) codeword latches the substitution flag, decoding on or off.
// R4: The carrier-loss-cleared flag latches when the carrier loss alarm clears.
// R5: The all-ones-cleared flag latches when the unframed all-ones alarm goes away.
// R6: The jitter-limit flag latches when the buffer fill is within 4 bits of its limit.
// R7: Latched flags stay set until their register is read, then clear after the read.
// R8: Event bits 1..0 and level bits 3..2 are unassigned and read as zero here.
// R9: Level bits 7..4 show the real-time 4-bit receive level code.
// R10: Loopback status sets after 5 s of loop-up and clears after 5 s of loop-down.
// R11: Loopback status is held at zero while automatic loopback is disabled.
// R12: The one-second flag sets on each second counted in recovered bit periods.
// R13: Carrier loss clears on 32 ones in 255 bits (E1) or 14 ones in 112 from the first (T1).
// R14: All-ones clears on more than two zeros in 512 bits (E1) or six zeros in 3 ms (T1).
// R15: An event in the cycle of the read of its register survives for the next read.
// R16: Line standard select low picks E1 rules, high picks T1 rules.
module rlsf_flags #(
    parameter int JA_W           = 8,                        // Jitter fill width
    parameter int UA1_T1_WIN_CYC = rlsf_pkg::UA1_T1_WIN_CYC, // 3 ms in clocks
    parameter int SEC_BITS_E1    = rlsf_pkg::SEC_BITS_E1,    // Bits per second, E1
    parameter int SEC_BITS_T1    = rlsf_pkg::SEC_BITS_T1     // Bits per second, T1
) (
    input  wire logic                     clk,                           // 100 MHz clock
    input  wire logic                     rst,                           // Async reset
    input  wire rlsf_pkg::rlsf_line_s     line,                          // Received bits
    input  wire logic [3:0]               rx_level_in,                   // Level code
    input  wire logic [JA_W-1:0]          ja_fill,                       // Jitter fill
    input  wire logic [JA_W-1:0]          ja_limit,                      // Usable limit
    input  wire logic                     loop_up_det,                   // Loop-up seen
    input  wire logic                     loop_down_det,                 // Loop-down seen
    input  wire logic                     line_standard_select,          // 0 E1, 1 T1
    input  wire logic                     auto_loopback_enable,          // Auto loopback
    input  wire logic                     rx_substitution_decode_enable, // Decode on
    input  wire rlsf_pkg::rlsf_host_req_s host_req,                      // Read request
    output logic [7:0]                    host_rdata,                    // Read data
    output logic                          host_rvalid,                   // Data valid
    output logic                          carrier_loss_alarm,            // Alarm level
    output logic                          unframed_all_ones_alarm,       // Alarm level
    output logic                          auto_remote_loopback_active    // Loopback state
);
    import rlsf_pkg::*;

    localparam logic [UA_WIN_W-1:0] UA_E1_LAST = UA_WIN_W'(UA1_WIN_E1 - 1);
    localparam logic [UA_WIN_W-1:0] UA_T1_LAST = UA_WIN_W'(UA1_T1_WIN_CYC - 1);
    localparam logic [JA_W:0]       JA_PAD     = (JA_W + 1)'(JA_MARGIN);

    typedef struct packed {
        logic [8:0]          zrun;
        logic [7:0]          mark_hist;
        logic [7:0]          pol_hist;
        logic                last_pol;
        logic                pre_pol;
        logic                cl_alarm;
        logic                cl_win_on;
        logic [8:0]          cl_win;
        logic [5:0]          cl_ones;
        logic                ua_alarm;
        logic [UA_WIN_W-1:0] ua_win;
        logic [2:0]          ua_zeros;
        rlsf_loop_e          lb;
        logic [2:0]          lb_secs;
        logic [7:2]          ev;
        logic                sec_flag;
        logic [3:0]          level;
        logic [7:0]          rdata;
        logic                rvalid;
    } rlsf_state_s;

    rlsf_state_s st_reg;
    rlsf_state_s st_next;
    logic        tick;
    logic        t1;
    logic        mark;
    logic        zero_bit;
    logic        rd_ev;
    logic        rd_lvl;
    logic        subst_hit;
    logic        ja_near;
    logic [7:2]  ev_set;

    ////////////////////////////////////////////////////////////////////////////////
    // One-second divider on recovered bit periods
    rlsf_sec_timer #(
        .SEC_BITS_E1 (SEC_BITS_E1),
        .SEC_BITS_T1 (SEC_BITS_T1)
    ) u_sec (
        .clk     (clk),
        .rst     (rst),
        .bit_en  (line.bit_en),
        .t1_mode (t1),
        .tick    (tick)
    );

    // Line decode and read decode
    assign t1       = line_standard_select; // R16
    assign mark     = line.pos | line.neg;
    assign zero_bit = line.bit_en & ~mark;
    assign ja_near  = ({1'b0, ja_fill} + JA_PAD) >= {1'b0, ja_limit};

    always_comb begin
        rd_ev  = 1'b0;
        rd_lvl = 1'b0;
        if (host_req.rd && host_req.addr == EVENT_FLAGS_ADDR) begin
            rd_ev = 1'b1;
        end else if (host_req.rd && host_req.addr == LEVEL_STATUS_ADDR) begin
            rd_lvl = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic       eff_pre;
        logic [7:0] w;
        logic [7:0] p;
        logic       hdb3;
        logic       b8zs;
        logic [2:0] zc;
        eff_pre   = st_reg.mark_hist[7] ? st_reg.pol_hist[7] : st_reg.pre_pol;
        w         = {st_reg.mark_hist[6:0], mark};
        p         = {st_reg.pol_hist[6:0], line.pos};
        hdb3      = mark && st_reg.mark_hist[1:0] == 2'b00 && line.pos == st_reg.last_pol;
        b8zs      = w == B8ZS_MARKS && p[4] == eff_pre && p[3] != p[4]
                    && p[1] == p[3] && p[0] != p[1];
        zc        = st_reg.ua_zeros;
        subst_hit = line.bit_en && (t1 ? b8zs : hdb3);
        st_next        = st_reg;
        st_next.rvalid = host_req.rd;
        st_next.level  = rx_level_in; // R9
        ev_set         = '0;

        // Zero runs; equality fires once per run, the latch holds the rest
        if (line.bit_en) begin
            if (mark) begin
                st_next.zrun = '0;
            end else if (st_reg.zrun != ZRUN_MAX) begin
                st_next.zrun = st_reg.zrun + 9'h001;
            end
        end
        ev_set[ZERO_RUN_FLAG_BIT]      = zero_bit && st_next.zrun == (t1 ? ZRUN_T1 : ZRUN_E1); // R1
        ev_set[LONG_ZERO_RUN_FLAG_BIT] = zero_bit && st_next.zrun == ZRUN_LONG; // R2

        // Codeword history; watched whatever the decoder setting is
        if (line.bit_en) begin
            st_next.mark_hist = w;
            st_next.pol_hist  = p;
            st_next.pre_pol   = eff_pre;
            if (mark) begin
                st_next.last_pol = line.pos;
            end
        end
        ev_set[SUBST_WORD_FLAG_BIT] = subst_hit; // R3

        // Carrier loss: E1 windows run back to back, T1 opens on the first one
        if (line.bit_en) begin
            if (!st_reg.cl_alarm) begin
                st_next.cl_win_on = 1'b0;
                st_next.cl_win    = '0;
                st_next.cl_ones   = '0;
                if (zero_bit && st_next.zrun == (t1 ? CL_SET_T1 : CL_SET_E1)) begin
                    st_next.cl_alarm = 1'b1;
                end
            end else if (st_reg.cl_win_on || !t1 || mark) begin
                st_next.cl_win_on = 1'b1;
                st_next.cl_win    = st_reg.cl_win + 9'h001;
                st_next.cl_ones   = st_reg.cl_ones + {5'h00, mark};
                if (st_next.cl_ones == (t1 ? CL_ONES_T1 : CL_ONES_E1)) begin
                    st_next.cl_alarm                = 1'b0; // R13
                    ev_set[CL_CLEARED_FLAG_BIT]     = 1'b1; // R4
                end else if (st_next.cl_win == (t1 ? CL_WIN_T1 : CL_WIN_E1)) begin
                    st_next.cl_win_on = 1'b0;
                    st_next.cl_win    = '0;
                    st_next.cl_ones   = '0;
                end
            end
        end

        // All-ones: E1 window in bits, T1 window in clocks
        if (t1 || line.bit_en) begin
            st_next.ua_win = st_reg.ua_win + UA_WIN_W'(1);
        end
        if (zero_bit && st_reg.ua_zeros != UA1_ZERO_MAX) begin
            zc = st_reg.ua_zeros + 3'h1;
        end
        st_next.ua_zeros = zc;
        if (t1 ? st_reg.ua_win >= UA_T1_LAST
               : (line.bit_en && st_reg.ua_win >= UA_E1_LAST)) begin
            st_next.ua_win   = '0;
            st_next.ua_zeros = '0;
            if (!st_reg.ua_alarm && zc <= (t1 ? UA1_SET_MAX_T1 : UA1_SET_MAX_E1)) begin
                st_next.ua_alarm = 1'b1;
            end else if (st_reg.ua_alarm && zc >= (t1 ? UA1_CLR_MIN_T1 : UA1_CLR_MIN_E1)) begin
                st_next.ua_alarm             = 1'b0; // R14
                ev_set[UA1_CLEARED_FLAG_BIT] = 1'b1; // R5
            end
        end

        ev_set[JA_LIMIT_FLAG_BIT] = ja_near; // R6

        // Automatic remote loopback, seconds counted while the code persists
        case (st_reg.lb)
            LB_OFF: begin
                if (!loop_up_det) begin
                    st_next.lb_secs = '0;
                end else if (tick) begin
                    st_next.lb_secs = st_reg.lb_secs + 3'h1;
                    if (st_next.lb_secs == LB_HOLD_SEC) begin
                        st_next.lb      = LB_ON; // R10
                        st_next.lb_secs = '0;
                    end
                end
            end
            LB_ON: begin
                if (!loop_down_det) begin
                    st_next.lb_secs = '0;
                end else if (tick) begin
                    st_next.lb_secs = st_reg.lb_secs + 3'h1;
                    if (st_next.lb_secs == LB_HOLD_SEC) begin
                        st_next.lb      = LB_OFF; // R10
                        st_next.lb_secs = '0;
                    end
                end
            end
            default: begin
                st_next.lb = LB_OFF;
            end
        endcase
        if (!auto_loopback_enable) begin
            st_next.lb      = LB_OFF; // R11
            st_next.lb_secs = '0;
        end

        // Read data captured before clearing; a set in the read cycle wins
        if (rd_ev) begin
            st_next.rdata = {st_reg.ev, 2'b00}; // R8
        end else if (rd_lvl) begin
            st_next.rdata = {st_reg.level, 2'b00, st_reg.lb == LB_ON, st_reg.sec_flag}; // R8
        end else if (host_req.rd) begin
            st_next.rdata = 8'h00;
        end
        st_next.ev       = (rd_ev ? '0 : st_reg.ev) | ev_set; // R7 R15
        st_next.sec_flag = (rd_lvl ? 1'b0 : st_reg.sec_flag) | tick; // R7 R12 R15
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign host_rdata                  = st_reg.rdata;
    assign host_rvalid                 = st_reg.rvalid;
    assign carrier_loss_alarm          = st_reg.cl_alarm;
    assign unframed_all_ones_alarm     = st_reg.ua_alarm;
    assign auto_remote_loopback_active = st_reg.lb == LB_ON;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_read_event;
        host_req.rd && host_req.addr == EVENT_FLAGS_ADDR;
    endsequence

    property p_zero_run;
        zero_bit && st_reg.zrun == (t1 ? ZRUN_T1 : ZRUN_E1) - 9'h001 |=> st_reg.ev[7];
    endproperty
    a_zero_run: assert property (p_zero_run) else $error("zero run flag missed"); // R1

    property p_long_run;
        zero_bit && st_reg.zrun == ZRUN_LONG - 9'h001 ##1 !$past(rd_ev) |-> st_reg.ev[6];
    endproperty
    a_long_run: assert property (p_long_run) else $error("long zero run flag missed"); // R2

    property p_subst;
        subst_hit && !rx_substitution_decode_enable |=> st_reg.ev[5];
    endproperty
    a_subst: assert property (p_subst) else $error("codeword flag missed"); // R3

    property p_hold;
        !rd_ev |=> (st_reg.ev & $past(st_reg.ev)) == $past(st_reg.ev);
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost without read"); // R7

    property p_read_clear;
        s_read_event ##0 !ja_near |=> !st_reg.ev[2] ##0 host_rvalid;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read"); // R7

    property p_set_wins;
        s_read_event ##0 ja_near |=> st_reg.ev[2];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost at read"); // R15

    property p_reserved;
        host_req.rd |=> host_rdata[3:2] == 2'b00 || $past(host_req.addr) == EVENT_FLAGS_ADDR;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // R8

    property p_level;
        rd_lvl |=> host_rdata[7:4] == $past(rx_level_in, 2);
    endproperty
    a_level: assert property (p_level) else $error("level code wrong"); // R9

    property p_lb_off;
        !auto_loopback_enable |=> !auto_remote_loopback_active;
    endproperty
    a_lb_off: assert property (p_lb_off) else $error("loopback active while disabled"); // R11

    property p_lb_on;
        auto_loopback_enable && !auto_remote_loopback_active && loop_up_det && tick
            && st_reg.lb_secs == LB_HOLD_SEC - 3'h1 |=> auto_remote_loopback_active;
    endproperty
    a_lb_on: assert property (p_lb_on) else $error("loopback did not engage"); // R10

    property p_sec;
        tick |=> st_reg.sec_flag ##1 st_reg.sec_flag || $past(rd_lvl);
    endproperty
    a_sec: assert property (p_sec) else $error("second flag missed"); // R12

endmodule

/* File: rtl/rlsf_pkg.sv */
package rlsf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map of the host port
    localparam logic [7:0] EVENT_FLAGS_ADDR  = 8'h08; // receive_event_flags
    localparam logic [7:0] LEVEL_STATUS_ADDR = 8'h09; // receive_level_and_loop_status

    // Bit positions in receive_event_flags
    localparam int ZERO_RUN_FLAG_BIT      = 7;
    localparam int LONG_ZERO_RUN_FLAG_BIT = 6;
    localparam int SUBST_WORD_FLAG_BIT    = 5;
    localparam int CL_CLEARED_FLAG_BIT    = 4;
    localparam int UA1_CLEARED_FLAG_BIT   = 3;
    localparam int JA_LIMIT_FLAG_BIT      = 2;
    localparam int EVENT_LOW_BIT          = 2;

    // Bit positions in receive_level_and_loop_status
    localparam int LEVEL_CODE_LSB         = 4;
    localparam int LOOPBACK_ACTIVE_BIT    = 1;
    localparam int SEC_TICK_FLAG_BIT      = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Zero runs, carrier loss set and clear criteria
    localparam logic [8:0] ZRUN_E1    = 9'h004;
    localparam logic [8:0] ZRUN_T1    = 9'h008;
    localparam logic [8:0] ZRUN_LONG  = 9'h010;
    localparam logic [8:0] ZRUN_MAX   = 9'h1ff;
    localparam logic [8:0] CL_SET_E1  = 9'h0ff;
    localparam logic [8:0] CL_SET_T1  = 9'h0c0;
    localparam logic [8:0] CL_WIN_E1  = 9'h0ff;
    localparam logic [8:0] CL_WIN_T1  = 9'h070;
    localparam logic [5:0] CL_ONES_E1 = 6'h20;
    localparam logic [5:0] CL_ONES_T1 = 6'h0e;

    // B8ZS mark pattern 000VB0VB, oldest bit first
    localparam logic [7:0] B8ZS_MARKS = 8'h1b;

    ////////////////////////////////////////////////////////////////////////////////
    // Unframed all-ones windows and thresholds
    localparam int         UA_WIN_W       = 19;
    localparam int         UA1_WIN_E1     = 512;
    localparam int         UA1_T1_WIN_MS  = 3;
    localparam int         CLK_FREQ_KHZ   = 100000;
    localparam int         UA1_T1_WIN_CYC = UA1_T1_WIN_MS * CLK_FREQ_KHZ;
    localparam logic [2:0] UA1_SET_MAX_E1 = 3'h1;
    localparam logic [2:0] UA1_CLR_MIN_E1 = 3'h3;
    localparam logic [2:0] UA1_SET_MAX_T1 = 3'h5;
    localparam logic [2:0] UA1_CLR_MIN_T1 = 3'h6;
    localparam logic [2:0] UA1_ZERO_MAX   = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing in recovered bit periods and seconds
    localparam int         SEC_CNT_W   = 21;
    localparam int         SEC_BITS_E1 = 2048000;
    localparam int         SEC_BITS_T1 = 1544000;
    localparam logic [2:0] LB_HOLD_SEC = 3'h5;
    localparam int         JA_MARGIN   = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic bit_en; // One recovered bit period
        logic pos;    // Positive mark
        logic neg;    // Negative mark
    } rlsf_line_s;

    typedef struct packed {
        logic       rd;   // Read strobe
        logic [7:0] addr; // Register address
    } rlsf_host_req_s;

    typedef enum logic {
        LB_OFF,
        LB_ON
    } rlsf_loop_e;

endpackage

/* File: rtl/rlsf_sec_timer.sv */
module rlsf_sec_timer #(
    parameter int SEC_BITS_E1 = rlsf_pkg::SEC_BITS_E1, // Bits per second, E1
    parameter int SEC_BITS_T1 = rlsf_pkg::SEC_BITS_T1  // Bits per second, T1
) (
    input  wire logic clk,    // System clock
    input  wire logic rst,    // Async reset
    input  wire logic bit_en, // Recovered bit period
    input  wire logic t1_mode, // Line standard
    output logic      tick    // One-second pulse
);
    import rlsf_pkg::*;

    localparam logic [SEC_CNT_W-1:0] E1_LAST = SEC_CNT_W'(SEC_BITS_E1 - 1);
    localparam logic [SEC_CNT_W-1:0] T1_LAST = SEC_CNT_W'(SEC_BITS_T1 - 1);

    typedef struct packed {
        logic [SEC_CNT_W-1:0] cnt;
        logic                 tick;
    } rlsf_tmr_s;

    rlsf_tmr_s st_reg;
    rlsf_tmr_s st_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Count bit periods; >= keeps a mode change from running past the end
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (bit_en) begin
            if (st_reg.cnt >= (t1_mode ? T1_LAST : E1_LAST)) begin
                st_next.cnt  = '0;
                st_next.tick = 1'b1; // R12
            end else begin
                st_next.cnt = st_reg.cnt + SEC_CNT_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

    property p_tick_period;
        @(posedge clk) disable iff (rst)
        tick |-> $past(bit_en);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick without bit period"); // R12

endmodule

/* File: tb/test_rx_line_status_flags.sv */
module test_rx_line_status_flags;
    timeunit 1ns;
    timeprecision 1ns;
    import rlsf_pkg::*;

    typedef struct packed {
        logic       t1; // Line standard
        logic [7:0] n;  // Zeros in the run
        logic [7:0] e;  // Expected event byte
    } rlsf_row_s;

    logic           clk;
    logic           rst;
    rlsf_line_s     line;
    logic [3:0]     lvl;
    logic [7:0]     fill;
    logic [7:0]     lim;
    logic           up;
    logic           dn;
    logic           std;
    logic           ale;
    logic           sde;
    rlsf_host_req_s req;
    logic [7:0]     rdata;
    logic           rvalid;
    logic           cl_al;
    logic           ua_al;
    logic           arl;
    logic           pol;
    logic [7:0]     d;
    int             n_mismatch;
    int             compares;
    rlsf_row_s      rows [8] = '{'{1'b0, 8'h03, 8'h00}, '{1'b0, 8'h04, 8'h80},
                                 '{1'b1, 8'h07, 8'h00}, '{1'b1, 8'h08, 8'h80},
                                 '{1'b0, 8'h0f, 8'h80}, '{1'b0, 8'h10, 8'hc0},
                                 '{1'b1, 8'h10, 8'hc0}, '{1'b1, 8'h04, 8'h00}};

    ////////////////////////////////////////////////////////////////////////////////
    // Short second and window so the run stays brief
    rlsf_flags #(.JA_W(8), .UA1_T1_WIN_CYC(64), .SEC_BITS_E1(20), .SEC_BITS_T1(16)) i_rlsf_flags (
        .clk                           (clk),
        .rst                           (rst),
        .line                          (line),
        .rx_level_in                   (lvl),
        .ja_fill                       (fill),
        .ja_limit                      (lim),
        .loop_up_det                   (up),
        .loop_down_det                 (dn),
        .line_standard_select          (std),
        .auto_loopback_enable          (ale),
        .rx_substitution_decode_enable (sde),
        .host_req                      (req),
        .host_rdata                    (rdata),
        .host_rvalid                   (rvalid),
        .carrier_loss_alarm            (cl_al),
        .unframed_all_ones_alarm       (ua_al),
        .auto_remote_loopback_active   (arl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Masked byte compare; unassigned bits are masked off except on the unmapped read
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] s, logic [7:0] m);
        compares++;
        if ((s & m) !== (e & m)) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e & m, s & m);
        end
    endtask

    task automatic chk1(string nm, logic e, logic s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask

    // One recovered bit, bit_en high for a single cycle
    task automatic bit_tx(logic p, logic n);
        @(negedge clk);
        line = '{1'b1, p, n};
        @(negedge clk);
        line = '0;
    endtask

    task automatic zeros(int k);
        repeat (k) bit_tx(1'b0, 1'b0);
    endtask

    // Alternating marks, so no bipolar violation is made by accident
    task automatic marks(int k);
        repeat (k) begin
            pol = ~pol;
            bit_tx(pol, ~pol);
        end
    endtask

    task automatic rd(logic [7:0] a);
        @(negedge clk);
        req = '{1'b1, a};
        // The answer stands for one cycle only, so take it here
        @(negedge clk);
        req = '0;
        chk1("rvalid", 1'b1, rvalid);
        d = rdata;
    endtask

    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog; the full sequence needs well under 15000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        rst = 1'b1; line = '0; lvl = 4'h0; fill = 8'h00; lim = 8'h64;
        up = 1'b0; dn = 1'b0; std = 1'b0; ale = 1'b0; sde = 1'b0;
        req = '0; pol = 1'b0; n_mismatch = 0; compares = 0;
        repeat (8) @(negedge clk);
        chk8("rst_outs", 8'h00, {4'h0, rvalid, cl_al, ua_al, arl}, 8'h0f);
        rst = 1'b0;
        rd(8'h08); chk8("event_rst", 8'h00, d, 8'hfc);
        rd(8'h0a); chk8("unmapped", 8'h00, d, 8'hff);
        for (int i = 0; i < 16; i++) begin
            lvl = i[3:0];
            rd(8'h09); chk8("level", {i[3:0], 4'h0}, d, 8'hf2);
        end
        marks(2); rd(8'h08);
        // Table of zero runs at both line standards
        foreach (rows[i]) begin
            std = rows[i].t1;
            marks(1); zeros(int'(rows[i].n)); marks(1);
            rd(8'h08); chk8("zero_runs", rows[i].e, d, 8'he4);
            rd(8'h08); chk8("after_read", 8'h00, d, 8'he4);
        end
        // Codewords, HDB3 with decoding off and B8ZS with decoding on
        std = 1'b0; marks(1); zeros(2); bit_tx(pol, ~pol); marks(1);
        rd(8'h08); chk8("hdb3", 8'h20, d, 8'he4);
        std = 1'b1; sde = 1'b1; marks(1); zeros(3); bit_tx(pol, ~pol); marks(1);
        zeros(1); bit_tx(pol, ~pol); marks(1);
        rd(8'h08); chk8("b8zs", 8'h20, d, 8'he4);
        // Jitter margin boundary, then an event that overlaps a read
        fill = 8'h5f; repeat (3) @(negedge clk); fill = 8'h00;
        rd(8'h08); chk8("ja_95", 8'h00, d, 8'h04);
        fill = 8'h60;
        rd(8'h08); chk8("ja_96", 8'h04, d, 8'h04);
        rd(8'h08); chk8("ja_during_read", 8'h04, d, 8'h04);
        fill = 8'h00;
        rd(8'h08); chk8("ja_last", 8'h04, d, 8'h04);
        rd(8'h08); chk8("ja_clear", 8'h00, d, 8'h04);
        // Carrier loss set at 255 zeros, cleared by ones
        std = 1'b0; marks(1); zeros(254); @(negedge clk);
        chk1("cl_254", 1'b0, cl_al);
        zeros(1); @(negedge clk); chk1("cl_255", 1'b1, cl_al);
        rd(8'h08); marks(510); @(negedge clk);
        chk1("cl_clear", 1'b0, cl_al);
        rd(8'h08); chk8("cl_cleared_flag", 8'h10, d, 8'h10);
        // Unframed all-ones set and cleared in E1 windows
        marks(1100); @(negedge clk); chk1("ua_set", 1'b1, ua_al);
        rd(8'h08); zeros(1100); @(negedge clk);
        chk1("ua_clear", 1'b0, ua_al);
        rd(8'h08); chk8("ua_cleared_flag", 8'h08, d, 8'h08);
        // Second tick, then loopback on and off
        marks(1); rd(8'h09); marks(20);
        rd(8'h09); chk8("sec_set", 8'h01, d, 8'h01);
        rd(8'h09); chk8("sec_clr", 8'h00, d, 8'h01);
        ale = 1'b1; up = 1'b1; marks(60); @(negedge clk);
        chk1("arl_early", 1'b0, arl);
        marks(60); @(negedge clk); chk1("arl_on", 1'b1, arl);
        rd(8'h09); chk8("arl_reg", 8'h02, d, 8'h02);
        up = 1'b0; dn = 1'b1; marks(60); @(negedge clk);
        chk1("arl_hold", 1'b1, arl);
        marks(60); @(negedge clk); chk1("arl_off", 1'b0, arl);
        dn = 1'b0; up = 1'b1; ale = 1'b0; marks(120); @(negedge clk);
        chk1("arl_disabled", 1'b0, arl);
        // Reset in mid-run with a flag pending; nothing may survive it
        fill = 8'h60; @(negedge clk); rst = 1'b1; fill = 8'h00;
        @(negedge clk); rst = 1'b0;
        rd(8'h08); chk8("event_mid_rst", 8'h00, d, 8'hfc);
        end_sim();
    end
endmodule
